// File: pkg/clock_source_defines.svh
// Constants for the clock source and start-up selection block
`ifndef CLOCK_SOURCE_DEFINES_SVH
`define CLOCK_SOURCE_DEFINES_SVH

// Register byte offsets on the bus
`define OFS_TRIM        32'h0000_0000
`define OFS_STATUS      32'h0000_0004

// Status word field positions
`define ST_SRC          0
`define ST_SUT          2
`define ST_SEQ          4
`define ST_RSVD         7
`define ST_CORE         8
`define ST_LEGACY       9
`define ST_CLOCK_SOURCE_SELECT_FUSES        10

// Clock source select codes as read from the fuses (0 = programmed)
`define CODE_INT_LO     4'h1
`define CODE_INT_HI     4'h4
`define CODE_RC_LO      4'h5
`define CODE_RC_HI      4'h8
`define CODE_LF_XTAL    4'h9

// Start-up time fuse codes
`define SUT_0           2'h0
`define SUT_1           2'h1
`define SUT_2           2'h2
`define SUT_3           2'h3

// Reset delay in watchdog oscillator cycles
`define WD_NONE         17'h0_0000
`define WD_4K           17'h0_1000
`define WD_64K          17'h1_0000

// Wake-up delay in selected source cycles
`define CK_6            17'h0_0006
`define CK_18           17'h0_0012
`define CK_1K           17'h0_0400
`define CK_32K          17'h0_8000

// AHB-Lite transfer type bit marking an active transfer
`define HTRANS_ACTIVE   1

`endif

// File: pkg/clock_source_pkg.sv
// Types shared by the clock source and start-up selection block
package clock_source_pkg;

	// Decoded clock source family
	typedef enum logic [1:0] {
		SRC_OTHER   = 2'h0,
		SRC_LF_XTAL = 2'h1,
		SRC_EXT_RC  = 2'h2,
		SRC_INT_RC  = 2'h3
	} source_t;

	// Start-up sequence, Gray coded along boot, delay, count, run
	typedef enum logic [2:0] {
		SEQ_BOOT  = 3'h0,
		SEQ_WDOG  = 3'h1,
		SEQ_CKCNT = 3'h3,
		SEQ_RUN   = 3'h2,
		SEQ_SLEEP = 3'h6
	} seq_state_t;

endpackage : clock_source_pkg

// File: src/startup_counter.sv
// Tick counter that reports when a loaded number of ticks has passed
`timescale 1ns/1ps
`include "clock_source_defines.svh"

module startup_counter import clock_source_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Control
	input  wire logic        load,
	input  wire logic [16:0] target,
	input  wire logic        tick,
	// Status
	output logic             done
);

	logic [16:0] count;   // Ticks seen since load
	logic [16:0] limit;   // Captured target
	wire  [16:0] count_inc = count + 17'h0_0001;

	// Load restarts the count; a zero target is done at once
	always_ff @(posedge clk) begin
		if (srst) begin
			count <= `WD_NONE;
			limit <= `WD_NONE;
			done  <= 1'b0;
		end else if (load) begin
			count <= `WD_NONE;
			limit <= target;
			done  <= (target == `WD_NONE);
		end else if (tick && !done) begin
			count <= count_inc;
			done  <= (count_inc == limit);
		end
	end

endmodule : startup_counter

// File: src/clock_source_startup_select.sv
// Clock source decode, start-up sequencing and oscillator trim register
`timescale 1ns/1ps
`include "clock_source_defines.svh"

// What this block does
// - Code 1001 selects low-frequency watch crystal
// - Option fuse adds 36 pF crystal caps
// - Crystal start-up: 1K/4K, 1K/64K, 32K/64K
// - Codes 0101 to 1000 select external RC
// - RC start-up: 18, 18+4K, 18+64K, 6+4K
// - Codes 0001 to 0100 select internal RC
// - Internal RC: 6 CK, reset delay 0/4K/64K
// - Reset loads calibration byte into trim
// - Trim zero slowest, FF fastest, monotonic
// - Watchdog oscillator times the reset delay
// - Trim register hidden in legacy mode
// - Fuse bit 1 unprogrammed, 0 programmed
// - Reset delay counts 0, 4096 or 65536 cycles
// - Selected source clocks the wake-up count
module clock_source_startup_select import clock_source_pkg::*; #(
	parameter logic [16:0] WDOG_LONG_CYCLES = `WD_64K,
	parameter logic [16:0] CK_LONG_CYCLES   = `CK_32K
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Configuration fuses, static pins
	input  wire logic [3:0]  CLOCK_SOURCE_SELECT_FUSES,
	input  wire logic [1:0]  STARTUP_TIME_FUSES,
	input  wire logic        OSCILLATOR_OPTION_FUSE,
	input  wire logic        LEGACY_MODE_FUSE,
	// Oscillator outputs, asynchronous to CLK
	input  wire logic        WDOG_OSC,
	input  wire logic        SOURCE_OSC,
	// Calibration and power control
	input  wire logic [7:0]  CAL_BYTE,
	input  wire logic        SLEEP_REQ,
	input  wire logic        WAKE_REQ,
	// Clock system controls
	output source_t          SOURCE_SEL,
	output logic      [1:0]  RC_RANGE,
	output logic             INT_CAP_EN,
	output logic      [7:0]  TRIM_VALUE,
	output logic             CORE_CLK_EN,
	output logic             RESET_DELAY_BUSY,
	output logic             FUSE_RESERVED
);

	// Fuse code to source family
	function automatic source_t decode_source(input logic [3:0] code);
		if (code == `CODE_LF_XTAL)
			return SRC_LF_XTAL;
		if (code >= `CODE_RC_LO && code <= `CODE_RC_HI)
			return SRC_EXT_RC;
		if (code >= `CODE_INT_LO && code <= `CODE_INT_HI)
			return SRC_INT_RC;
		return SRC_OTHER;
	endfunction : decode_source

	// Reset delay in watchdog cycles; reserved codes take the longest
	function automatic logic [16:0] wd_target(input source_t s,
	                                          input logic [1:0] startup_time_fuses);
		case (s)
			SRC_LF_XTAL: begin
				return (startup_time_fuses == `SUT_0) ? `WD_4K : WDOG_LONG_CYCLES;
			end
			SRC_EXT_RC: begin
				case (startup_time_fuses)
					`SUT_0: return `WD_NONE;
					`SUT_2: return WDOG_LONG_CYCLES;
					default: return `WD_4K;
				endcase
			end
			SRC_INT_RC: begin
				case (startup_time_fuses)
					`SUT_0: return `WD_NONE;
					`SUT_1: return `WD_4K;
					default: return WDOG_LONG_CYCLES;
				endcase
			end
			default: return WDOG_LONG_CYCLES;
		endcase
	endfunction : wd_target

	// Wake-up delay in source cycles; reserved codes take the longest, except internal RC code 11 at 6
	function automatic logic [16:0] ck_target(input source_t s,
	                                          input logic [1:0] startup_time_fuses);
		case (s)
			SRC_LF_XTAL: begin
				return (startup_time_fuses[1] == 1'b0) ? `CK_1K : CK_LONG_CYCLES;
			end
			SRC_EXT_RC: begin
				return (startup_time_fuses == `SUT_3) ? `CK_6 : `CK_18;
			end
			SRC_INT_RC: return `CK_6;
			default: return CK_LONG_CYCLES;
		endcase
	endfunction : ck_target

	// Two-stage synchronisers for pins; fuses need no reset
	logic [7:0] fuse_meta;   // First stage, read only by fuse_sync
	logic [7:0] fuse_sync;   // Clock_source_select_fuses, sut, option, legacy
	logic [1:0] osc_meta;    // First stage, read only by osc_sync
	logic [1:0] osc_sync;    // Watchdog, source oscillator
	logic [1:0] osc_prev;    // For rising-edge detection

	// Sample the static fuse levels
	always_ff @(posedge CLK) begin
		fuse_meta <= {CLOCK_SOURCE_SELECT_FUSES, STARTUP_TIME_FUSES,
		              OSCILLATOR_OPTION_FUSE, LEGACY_MODE_FUSE};
		fuse_sync <= fuse_meta;
	end

	// Oscillators are far slower than CLK, so edges can be counted here.
	// No reset: the edge detector keeps tracking the pin through reset,
	// so a high oscillator at release is not mistaken for a rising edge
	always_ff @(posedge CLK) begin
		osc_meta <= {WDOG_OSC, SOURCE_OSC};
		osc_sync <= osc_meta;
		osc_prev <= osc_sync;
	end

	// Fuse fields; programmed bits read as zero
	wire [3:0] clock_source_select_fuses       = fuse_sync[7:4];
	wire [1:0] startup_time_fuses         = fuse_sync[3:2];
	wire       opt_prog    = ~fuse_sync[1];
	wire       legacy_mode = ~fuse_sync[0];
	wire       wd_tick     = osc_sync[1] & ~osc_prev[1];
	wire       ck_tick     = osc_sync[0] & ~osc_prev[0];

	// Live decode of the fuse settings
	wire source_t     src_now = decode_source(clock_source_select_fuses);
	wire       [16:0] wd_now  = wd_target(src_now, startup_time_fuses);
	wire       [16:0] ck_now  = ck_target(src_now, startup_time_fuses);
	wire       [3:0]  rc_base = (src_now == SRC_EXT_RC) ? `CODE_RC_LO
	                                                    : `CODE_INT_LO;
	wire       [3:0]  rc_off  = clock_source_select_fuses - rc_base;
	wire       [1:0]  range_now = (src_now == SRC_EXT_RC ||
	                               src_now == SRC_INT_RC) ? rc_off[1:0]
	                                                      : 2'h0;
	// Caps only for crystal and RC; left off with the internal RC
	wire cap_now  = opt_prog & (src_now == SRC_LF_XTAL ||
	                            src_now == SRC_EXT_RC);
	wire rsvd_now = (src_now == SRC_OTHER) ||
	                ((src_now == SRC_LF_XTAL || src_now == SRC_INT_RC) &&
	                 startup_time_fuses == `SUT_3);

	// Registered clock system controls
	always_ff @(posedge CLK) begin
		if (SRST) begin
			SOURCE_SEL    <= SRC_OTHER;
			RC_RANGE      <= 2'h0;
			INT_CAP_EN    <= 1'b0;
			FUSE_RESERVED <= 1'b0;
		end else begin
			SOURCE_SEL    <= src_now;
			RC_RANGE      <= range_now;
			INT_CAP_EN    <= cap_now;
			FUSE_RESERVED <= rsvd_now;
		end
	end

	// Start-up sequencer
	seq_state_t state;         // Current sequence step
	seq_state_t next_state;    // Step after this edge
	logic       wd_done;       // Reset delay expired
	logic       ck_done;       // Wake-up count expired

	// Targets are captured on load, so fuse changes later do not matter
	wire wd_load = (state == SEQ_BOOT);
	wire ck_load = (state == SEQ_WDOG && wd_done) ||
	               (state == SEQ_SLEEP && WAKE_REQ);

	// Next step of the sequence
	always_comb begin
		next_state = state;
		case (state)
			SEQ_BOOT:  next_state = SEQ_WDOG;
			SEQ_WDOG: begin
				if (wd_done)
					next_state = SEQ_CKCNT;
			end
			SEQ_CKCNT: begin
				if (ck_done)
					next_state = SEQ_RUN;
			end
			SEQ_RUN: begin
				if (SLEEP_REQ)
					next_state = SEQ_SLEEP;
			end
			SEQ_SLEEP: begin
				// Wake skips the reset delay, only the source count runs
				if (WAKE_REQ)
					next_state = SEQ_CKCNT;
			end
			default:   next_state = SEQ_BOOT;
		endcase
	end

	// Sequence state and gate outputs
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state            <= SEQ_BOOT;
			CORE_CLK_EN      <= 1'b0;
			RESET_DELAY_BUSY <= 1'b1;
		end else begin
			state            <= next_state;
			CORE_CLK_EN      <= (next_state == SEQ_RUN);
			RESET_DELAY_BUSY <= (next_state == SEQ_BOOT ||
			                     next_state == SEQ_WDOG);
		end
	end

	// Reset delay timed by the watchdog oscillator, whatever the source
	startup_counter u_wdog_delay (
		.clk    (CLK),
		.srst   (SRST),
		.load   (wd_load),
		.target (wd_now),
		.tick   (wd_tick),
		.done   (wd_done)
	);

	// Wake-up count timed by the selected source itself
	startup_counter u_source_delay (
		.clk    (CLK),
		.srst   (SRST),
		.load   (ck_load),
		.target (ck_now),
		.tick   (ck_tick),
		.done   (ck_done)
	);

	// AHB-Lite slave, zero wait state, always OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	wire addr_phase = HSEL & HTRANS[`HTRANS_ACTIVE] & HREADY;
	wire sel_trim   = (HADDR == `OFS_TRIM) & ~legacy_mode;
	wire sel_status = (HADDR == `OFS_STATUS);

	logic       wr_trim;       // Data phase of a trim write
	logic [31:0] status_word;  // Live status view

	// Remember a trim write for its data phase
	always_ff @(posedge CLK) begin
		if (SRST)
			wr_trim <= 1'b0;
		else if (addr_phase)
			wr_trim <= HWRITE & sel_trim;
		else
			wr_trim <= 1'b0;
	end

	// Trim follows the calibration byte in every reset, then software
	always_ff @(posedge CLK) begin
		if (SRST)
			TRIM_VALUE <= CAL_BYTE;
		else if (wr_trim)
			TRIM_VALUE <= HWDATA[7:0];
	end

	// Forward a write in flight so back-to-back read sees it
	wire [7:0] trim_read = wr_trim ? HWDATA[7:0] : TRIM_VALUE;

	// Status assembled from the block's own state
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ST_SRC +: 2]   = SOURCE_SEL;
		status_word[`ST_SUT +: 2]   = startup_time_fuses;
		status_word[`ST_SEQ +: 3]   = state;
		status_word[`ST_RSVD]       = FUSE_RESERVED;
		status_word[`ST_CORE]       = CORE_CLK_EN;
		status_word[`ST_LEGACY]     = legacy_mode;
		status_word[`ST_CLOCK_SOURCE_SELECT_FUSES +: 4] = clock_source_select_fuses;
	end

	// Unmapped or hidden addresses read as zero
	wire [31:0] read_mux = sel_trim   ? {24'h00_0000, trim_read} :
	                       sel_status ? status_word : 32'h0000_0000;

	// Read data captured at the address phase, held until the next read
	always_ff @(posedge CLK) begin
		if (SRST)
			HRDATA <= 32'h0000_0000;
		else if (addr_phase && !HWRITE)
			HRDATA <= read_mux;
	end

	// Checks on the design's own behaviour
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_legacy_write;
		addr_phase && HWRITE && HADDR == `OFS_TRIM && legacy_mode;
	endsequence

	sequence s_wake;
		state == SEQ_SLEEP && WAKE_REQ;
	endsequence

	property p_lf_source;
		clock_source_select_fuses == `CODE_LF_XTAL |=> SOURCE_SEL == SRC_LF_XTAL;
	endproperty
	a_lf_source: assert property (p_lf_source)
		else $error("crystal code did not select crystal");

	property p_caps;
		src_now == SRC_LF_XTAL && !fuse_sync[1] |=> INT_CAP_EN;
	endproperty
	a_caps: assert property (p_caps)
		else $error("programmed option fuse did not enable caps");

	property p_lf_sut;
		src_now == SRC_LF_XTAL && startup_time_fuses == `SUT_0 |->
			wd_now == `WD_4K && ck_now == `CK_1K;
	endproperty
	a_lf_sut: assert property (p_lf_sut)
		else $error("crystal start-up code 00 wrong");

	property p_ext_rc;
		clock_source_select_fuses >= `CODE_RC_LO && clock_source_select_fuses <= `CODE_RC_HI |=>
			SOURCE_SEL == SRC_EXT_RC &&
			RC_RANGE == 2'(($past(clock_source_select_fuses) - `CODE_RC_LO));
	endproperty
	a_ext_rc: assert property (p_ext_rc)
		else $error("external RC range decode wrong");

	property p_ext_sut;
		src_now == SRC_EXT_RC && startup_time_fuses == `SUT_3 |->
			ck_now == `CK_6 && wd_now == `WD_4K;
	endproperty
	a_ext_sut: assert property (p_ext_sut)
		else $error("external RC start-up code 11 wrong");

	property p_int_rc;
		clock_source_select_fuses >= `CODE_INT_LO && clock_source_select_fuses <= `CODE_INT_HI |=>
			SOURCE_SEL == SRC_INT_RC && !INT_CAP_EN;
	endproperty
	a_int_rc: assert property (p_int_rc)
		else $error("internal RC code did not select internal RC");

	property p_int_sut;
		src_now == SRC_INT_RC && startup_time_fuses == `SUT_2 |->
			ck_now == `CK_6 && wd_now == WDOG_LONG_CYCLES;
	endproperty
	a_int_sut: assert property (p_int_sut)
		else $error("internal RC default start-up wrong");

	property p_trim_reset;
		disable iff (1'b0)
		SRST |=> TRIM_VALUE == $past(CAL_BYTE);
	endproperty
	a_trim_reset: assert property (p_trim_reset)
		else $error("trim not loaded from calibration byte");

	property p_trim_write;
		wr_trim |=> TRIM_VALUE == $past(HWDATA[7:0]);
	endproperty
	a_trim_write: assert property (p_trim_write)
		else $error("trim write not taken");

	property p_legacy;
		s_legacy_write ##1 !SRST |=> $stable(TRIM_VALUE);
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("trim written in legacy mode");

	property p_wdog_hold;
		state == SEQ_WDOG && !wd_done |=> state == SEQ_WDOG;
	endproperty
	a_wdog_hold: assert property (p_wdog_hold)
		else $error("left reset delay early");

	property p_wake;
		s_wake |=> !CORE_CLK_EN [*6];
	endproperty
	a_wake: assert property (p_wake)
		else $error("core clock ran before wake-up count");

	property p_gate;
		CORE_CLK_EN |-> state == SEQ_RUN && wd_done && ck_done;
	endproperty
	a_gate: assert property (p_gate)
		else $error("core clock ungated before delays ended");

endmodule : clock_source_startup_select

// File: verification/clock_source_startup_select_test.sv
// Self-checking bench for clock source decode, start-up and trim register
`timescale 1ns/1ps

module clock_source_startup_select_test import clock_source_pkg::*; ;
	localparam int WD_L = 40;	// Shortened long watchdog count
	localparam int CK_L = 30;	// Shortened long source count
	localparam int N    = 13;	// Fuse settings tried

	// Fuse settings and expected decode, one column per setting
	int t_cks [N] = '{9, 9, 9, 9, 5, 6, 7, 8, 1, 2, 3, 4, 0};
	int t_sut [N] = '{0, 1, 2, 3, 0, 2, 1, 3, 0, 1, 3, 2, 0};
	int t_opt [N] = '{0, 1, 1, 1, 0, 1, 1, 1, 1, 1, 1, 1, 1};
	int t_src [N] = '{1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 0};
	int t_rng [N] = '{0, 0, 0, 0, 0, 1, 2, 3, 0, 1, 2, 3, 0};
	int t_cap [N] = '{1, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
	int t_rsv [N] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 1, 0, 1};
	// Expected watchdog and source tick counts
	int t_wd [N] = '{4096, WD_L, WD_L, WD_L, 0, WD_L, 4096, 4096, 0, 4096,
		WD_L, WD_L, WD_L};
	int t_ck [N] = '{1024, 1024, CK_L, CK_L, 18, 18, 18, 6, 6, 6, 6, 6,
		CK_L};

	logic        clk       = 1'b0;	// System clock
	logic        srst      = 1'b1;	// Synchronous reset
	logic        hsel      = 1'b0;	// Bus select
	logic [31:0] haddr     = 32'h0000_0000;	// Bus address
	logic [1:0]  htrans    = 2'h0;	// Transfer type
	logic        hwrite    = 1'b0;	// Write strobe
	logic [2:0]  hsize     = 3'h2;	// Word size
	logic [31:0] hwdata    = 32'h0000_0000;	// Write data
	wire  [31:0] hrdata;	// Read data
	wire         hreadyout;	// Slave ready
	wire         hready;	// Bus ready, looped back
	wire         hresp;	// Response
	logic [3:0]  cks       = 4'h1;	// Source select fuses
	logic [1:0]  startup_time_fuses       = 2'h2;	// Start-up fuses
	logic        opt       = 1'b1;	// Option fuse
	logic        legacy    = 1'b1;	// Legacy fuse, 0 is active
	logic [1:0]  osc_div   = 2'h0;	// Oscillator divider
	logic [7:0]  cal       = 8'h5A;	// Calibration byte
	logic        sleep_req = 1'b0;	// Sleep request
	logic        wake_req  = 1'b0;	// Wake request
	source_t     source_sel;	// Decoded source
	wire  [1:0]  rc_range;	// Range mode
	wire         cap_en;	// Internal caps
	wire  [7:0]  trim;	// Trim value out
	wire         core_en;	// Core clock enable
	wire         busy;	// Reset delay running
	wire         rsvd;	// Reserved setting
	int          errors    = 0;	// Mismatches
	int          cmp_count = 0;	// Comparisons
	logic [31:0] rdv;	// Last read data
	int          nb;	// Cycles until delay end
	int          nc;	// Cycles until core clock

	assign hready = hreadyout;

	// 50 MHz clock
	always #10 clk = ~clk;

	// Both oscillators: 2 cycles high, 2 low, kept apart by phase
	always @(posedge clk) begin
		osc_div <= osc_div + 2'h1;
	end

	clock_source_startup_select #(
		.WDOG_LONG_CYCLES (17'(WD_L)),
		.CK_LONG_CYCLES   (17'(CK_L))
	) u_dut (
		.CLK                       (clk),
		.SRST                      (srst),
		.HSEL                      (hsel),
		.HADDR                     (haddr),
		.HTRANS                    (htrans),
		.HWRITE                    (hwrite),
		.HSIZE                     (hsize),
		.HWDATA                    (hwdata),
		.HREADY                    (hready),
		.HRDATA                    (hrdata),
		.HREADYOUT                 (hreadyout),
		.HRESP                     (hresp),
		.CLOCK_SOURCE_SELECT_FUSES (cks),
		.STARTUP_TIME_FUSES        (startup_time_fuses),
		.OSCILLATOR_OPTION_FUSE    (opt),
		.LEGACY_MODE_FUSE          (legacy),
		.WDOG_OSC                  (osc_div[1]),
		.SOURCE_OSC                (~osc_div[1]),
		.CAL_BYTE                  (cal),
		.SLEEP_REQ                 (sleep_req),
		.WAKE_REQ                  (wake_req),
		.SOURCE_SEL                (source_sel),
		.RC_RANGE                  (rc_range),
		.INT_CAP_EN                (cap_en),
		.TRIM_VALUE                (trim),
		.CORE_CLK_EN               (core_en),
		.RESET_DELAY_BUSY          (busy),
		.FUSE_RESERVED             (rsvd)
	);

	// Compare and count; report a mismatch at once
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// One single word transfer; address phase, then data phase
	task automatic xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : xfer

	// Cycles with the reset delay busy, and cycles until the core clock
	task automatic wait_core(output int b, output int c);
		b = 0;
		c = 0;
		for (int n = 1; n < 30000; n++) begin
			@(posedge clk);
			if (busy === 1'b1) b++;
			if (core_en === 1'b1) begin
				c = n;
				break;
			end
		end
	endtask : wait_core

	// Reset with one fuse setting, time the start-up, check the decode
	task automatic run_cfg(input int i);
		int w;
		int c;
		w = t_wd[i];
		c = t_ck[i];
		cks  <= 4'(t_cks[i]);
		startup_time_fuses  <= 2'(t_sut[i]);
		opt  <= t_opt[i][0];
		cal  <= 8'(48 + i);
		srst <= 1'b1;
		cyc(4);
		chk("trim after reset", trim, 32'(48 + i));
		chk("gated in reset", core_en, 0);
		srst <= 1'b0;
		wait_core(nb, nc);
		chk("reset delay", nb >= 4 * w - 5 && nb <= 4 * w + 9, 1);
		chk("start-up", nc >= 4 * (w + c) - 4 && nc <= 4 * (w + c) + 14,
			1);
		chk("source", source_sel, t_src[i]);
		chk("range", rc_range, t_rng[i]);
		chk("caps", cap_en, t_cap[i]);
		chk("reserved", rsvd, t_rsv[i]);
		xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rdv);
		chk("status", rdv & 32'h0000_3DFF, 32'({4'(t_cks[i]), 1'b0, 1'b1,
			1'(t_rsv[i]), 3'h2, 2'(t_sut[i]), 2'(t_src[i])}));
	endtask : run_cfg

	// Verdict and end of run
	task automatic close_out;
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// Hang guard, beyond the longest expected run of about 76000 cycles
	initial begin
		#(95000 * 20);
		errors++;
		close_out();
	end

	// Main sequence
	initial begin
		cyc(16);
		for (int i = 0; i < N; i++) begin
			run_cfg(i);
		end
		// Trim writes, read one idle cycle after the write, extremes
		// No memory write is in flight, so the full trim range is fair
		xfer(1'b1, 32'h0000_0000, 32'h0000_00A5, rdv);
		xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rdv);
		chk("trim readback", rdv, 32'h0000_00A5);
		chk("okay", hresp, 0);
		xfer(1'b1, 32'h0000_0000, 32'h0000_0000, rdv);
		cyc(1);
		chk("trim slowest", trim, 32'h0000_0000);
		xfer(1'b1, 32'h0000_0000, 32'h0000_00FF, rdv);
		cyc(1);
		chk("trim fastest", trim, 32'h0000_00FF);
		// Unmapped place reads zero and leaves trim alone
		xfer(1'b1, 32'h0000_0010, 32'h0000_0011, rdv);
		xfer(1'b0, 32'h0000_0010, 32'h0000_0000, rdv);
		chk("unmapped", rdv, 32'h0000_0000);
		chk("trim kept", trim, 32'h0000_00FF);
		// Legacy mode hides the trim register
		legacy <= 1'b0;
		cyc(4);
		xfer(1'b1, 32'h0000_0000, 32'h0000_0033, rdv);
		xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rdv);
		cyc(1);
		chk("legacy read", rdv, 32'h0000_0000);
		chk("legacy write", trim, 32'h0000_00FF);
		legacy <= 1'b1;
		// Sleep, then wake: only the source count runs
		sleep_req <= 1'b1;
		cyc(2);
		sleep_req <= 1'b0;
		cyc(2);
		chk("sleep gates", core_en, 0);
		wake_req <= 1'b1;
		wait_core(nb, nc);
		wake_req <= 1'b0;
		chk("wake no delay", nb, 0);
		chk("wake count", nc >= 4 * CK_L - 4 && nc <= 4 * CK_L + 14,
			1);
		cyc(4);
		close_out();
	end
endmodule : clock_source_startup_select_test
